// >>> common/pss_pkg.sv
package pss_pkg;
	localparam int unsigned CLK_HZ = 20_000_000;
	// tick rate for time-out and alarm timing: 1 ms
	localparam int unsigned TICK_MS = 1;
	localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;
	localparam logic [17:0] TICK_LAST = 18'(TICK_CYC - 1);
	localparam int unsigned ALARM_S = 3;
	localparam logic [11:0] ALARM_TICKS = 12'(ALARM_S * 1000 / TICK_MS);
	localparam int unsigned STEP_SPACING_MS = 50;
	localparam logic [2:0] POS_REST = 3'h0;
	localparam logic [2:0] POS_FIRST = 3'h1;
	localparam logic [2:0] POS_MAX = 3'h7;
	localparam logic [11:0] TICKS_ZERO = 12'h000;
	localparam logic [11:0] TICKS_ONE = 12'h001;

	typedef enum logic [1:0]
	{
		PSS_IDLE = 2'b00,
		PSS_STEP = 2'b01,
		PSS_WORD = 2'b10
	} pss_state_t;

	typedef enum logic
	{
		PSS_TIMEOUT = 1'b0,
		PSS_ACK = 1'b1
	} pss_mode_t;

	typedef enum logic
	{
		PSS_RESTORE = 1'b0,
		PSS_SYNC = 1'b1
	} pss_pwr_t;

	typedef struct packed
	{
		logic [2:0] upper_pos;
		logic [11:0] timeout_ticks;
		pss_mode_t step_mode;
		pss_mode_t direct_path_apply_mode;
		pss_pwr_t pwr_mode;
	} pss_cfg_t;

	typedef struct packed
	{
		logic step_alarm;
		logic range_alarm;
		logic word_alarm;
		logic powerup_position_alarm;
	} pss_alarm_t;

	function automatic logic pss_in_range(input logic [2:0] p,
		input logic [2:0] upper);
		pss_in_range = (p != POS_REST) && (p <= upper);
	endfunction
endpackage

// >>> hdl/pss_tick.sv
`timescale 1ns/1ns
module pss_tick
	import pss_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic srst_i,
	output logic tick_o
);
	logic [17:0] cnt_ff;
	logic [17:0] nxt_cnt;
	logic wrap;

	assign wrap = (cnt_ff == TICK_LAST);
	assign nxt_cnt = wrap ? 18'h0_0000 : cnt_ff + 18'h0_0001;

	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
		begin
			cnt_ff <= 18'h0_0000;
			tick_o <= 1'b0;
		end
		else
		begin
			cnt_ff <= nxt_cnt;
			tick_o <= wrap;
		end
	end
endmodule

// >>> hdl/pss_alarm.sv
`timescale 1ns/1ns
module pss_alarm
	import pss_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic srst_i,
	input wire logic tick_i,
	input wire logic trig_i,
	output logic alarm_o
);
	logic [11:0] cnt_ff;
	logic [11:0] nxt_cnt;

	// retrigger restarts the full hold time
	assign nxt_cnt = trig_i ? ALARM_TICKS :
		(tick_i && cnt_ff != TICKS_ZERO) ? cnt_ff - TICKS_ONE : cnt_ff;

	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
		begin
			cnt_ff <= TICKS_ZERO;
			alarm_o <= 1'b0;
		end
		else
		begin
			cnt_ff <= nxt_cnt;
			alarm_o <= (nxt_cnt != TICKS_ZERO);
		end
	end
endmodule

// >>> hdl/pss_top.sv
// Overview of operation
// - step-up rising edge advances pre-selection, wrapping after upper position to 1
// - direct word above upper is ignored and range alarm holds 3 s
// - step timed mode applies pre-selection after time-out of step inactivity
// - step ack mode: no ack before time-out drops change, step alarm 3 s
// - each step edge restarts timer and shows pending position
// - step ack mode: step confirm rising edge in time applies pre-selection
// - direct word is unsigned binary, 1..7 positions, zero is rest
// - all-zero word makes no pre-selection, change or alarm
// - word timed mode applies after time-out since last word change
// - word ack mode: word confirm rising edge in time applies pre-selection
// - pending step sequence ignores word; pending word sequence ignores step
// - word ack mode: no ack before time-out rejects, word alarm 3 s
// - applied position kept in storage; power-up restores or syncs to word
// - separate confirm inputs per path, each acting on its own path
// - sync power-up with rest or bad word gives position 0 and alarm
// - restored out-of-range position gives position 0 and power-up alarm
`timescale 1ns/1ns
module pss_top
	import pss_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic srst_i,
	input wire pss_cfg_t cfg_i,
	input wire logic step_up_i,
	input wire logic step_confirm_i,
	input wire logic direct_word_bit0_i,
	input wire logic direct_word_bit1_i,
	input wire logic direct_word_bit2_i,
	input wire logic direct_path_confirm_i,
	// power-up request and position held in non-volatile storage
	input wire logic powerup_i,
	input wire logic [2:0] nv_pos_i,
	output logic nv_wr_o,
	output logic [2:0] nv_pos_o,
	output logic [2:0] pos_bin_o,
	output logic [7:0] pos_onehot_o,
	output logic pos_changed_o,
	output logic pending_o,
	output logic [2:0] pending_pos_o,
	output pss_alarm_t alarm_o
);
	pss_state_t state_ff;
	pss_state_t nxt_state;
	logic [2:0] pre_ff;
	logic [2:0] nxt_pre;
	logic [2:0] pos_ff;
	logic [2:0] nxt_pos;
	logic [11:0] tmr_ff;
	logic [11:0] nxt_tmr;
	logic step_d_ff;
	logic sack_d_ff;
	logic wack_d_ff;
	logic [2:0] word_d_ff;
	logic tick;
	logic [2:0] word;
	logic step_rise;
	logic sack_rise;
	logic wack_rise;
	logic word_chg;
	logic word_ok;
	logic expired;
	logic apply;
	logic restart;
	logic trig_step;
	logic trig_range;
	logic trig_word;
	logic trig_pwr;
	logic [2:0] step_next;
	logic pwr_ok;
	logic [2:0] pwr_pos;

	pss_tick u_tick
	(
		.core_clk_i(core_clk_i),
		.srst_i(srst_i),
		.tick_o(tick)
	);

	assign word = {direct_word_bit2_i, direct_word_bit1_i,
		direct_word_bit0_i};
	assign step_rise = step_up_i && !step_d_ff;
	assign sack_rise = step_confirm_i && !sack_d_ff;
	assign wack_rise = direct_path_confirm_i && !wack_d_ff;
	assign word_chg = (word != word_d_ff);
	assign word_ok = pss_in_range(word, cfg_i.upper_pos);
	assign expired = tick && (tmr_ff == TICKS_ONE);
	// relies on the driver keeping step pulses 50 ms apart
	assign step_next = (pre_ff >= cfg_i.upper_pos || pre_ff == POS_REST) ?
		POS_FIRST : pre_ff + POS_FIRST;
	assign pwr_pos = (cfg_i.pwr_mode == PSS_SYNC) ? word : nv_pos_i;
	assign pwr_ok = pss_in_range(pwr_pos, cfg_i.upper_pos);

	always_comb
	begin
		nxt_state = state_ff;
		nxt_pre = pre_ff;
		nxt_pos = pos_ff;
		nxt_tmr = (tick && tmr_ff != TICKS_ZERO) ? tmr_ff - TICKS_ONE : tmr_ff;
		apply = 1'b0;
		restart = 1'b0;
		trig_step = 1'b0;
		trig_range = 1'b0;
		trig_word = 1'b0;
		trig_pwr = 1'b0;
		if (powerup_i)
		begin
			// power-up takes effect at once, no time-out or confirm
			nxt_state = PSS_IDLE;
			nxt_pos = pwr_ok ? pwr_pos : POS_REST;
			trig_pwr = !pwr_ok;
			apply = 1'b1;
		end
		else
		begin
			case (state_ff)
				PSS_IDLE:
				begin
					if (step_rise)
					begin
						nxt_pre = (pos_ff == POS_REST) ? POS_FIRST : step_next;
						if (pos_ff != POS_REST)
							nxt_pre = (pos_ff >= cfg_i.upper_pos) ?
								POS_FIRST : pos_ff + POS_FIRST;
						nxt_state = PSS_STEP;
						restart = 1'b1;
					end
					else if (word_chg && word != POS_REST)
					begin
						if (word_ok)
						begin
							nxt_pre = word;
							nxt_state = PSS_WORD;
							restart = 1'b1;
						end
						else
							trig_range = 1'b1;
					end
				end
				PSS_STEP:
				begin
					// word inputs are not looked at here
					if (step_rise)
					begin
						nxt_pre = step_next;
						restart = 1'b1;
					end
					else if (cfg_i.step_mode == PSS_ACK && sack_rise)
					begin
						nxt_pos = pre_ff;
						apply = 1'b1;
						nxt_state = PSS_IDLE;
					end
					else if (expired)
					begin
						nxt_state = PSS_IDLE;
						if (cfg_i.step_mode == PSS_TIMEOUT)
						begin
							nxt_pos = pre_ff;
							apply = 1'b1;
						end
						else
							trig_step = 1'b1;
					end
				end
				PSS_WORD:
				begin
					// step input is not looked at here
					if (word_chg)
					begin
						restart = 1'b1;
						if (word == POS_REST)
							restart = 1'b1;
						else if (word_ok)
							nxt_pre = word;
						else
							trig_range = 1'b1;
					end
					else if (cfg_i.direct_path_apply_mode == PSS_ACK &&
						wack_rise)
					begin
						nxt_pos = pre_ff;
						apply = 1'b1;
						nxt_state = PSS_IDLE;
					end
					else if (expired)
					begin
						nxt_state = PSS_IDLE;
						if (cfg_i.direct_path_apply_mode == PSS_TIMEOUT)
						begin
							nxt_pos = pre_ff;
							apply = 1'b1;
						end
						else
							trig_word = 1'b1;
					end
				end
				default:
				begin
					nxt_state = PSS_IDLE;
				end
			endcase
		end
		if (restart)
			nxt_tmr = cfg_i.timeout_ticks;
	end

	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
		begin
			state_ff <= PSS_IDLE;
			pre_ff <= POS_REST;
			pos_ff <= POS_REST;
			tmr_ff <= TICKS_ZERO;
			step_d_ff <= 1'b0;
			sack_d_ff <= 1'b0;
			wack_d_ff <= 1'b0;
			word_d_ff <= POS_REST;
		end
		else
		begin
			state_ff <= nxt_state;
			pre_ff <= nxt_pre;
			pos_ff <= nxt_pos;
			tmr_ff <= nxt_tmr;
			step_d_ff <= step_up_i;
			sack_d_ff <= step_confirm_i;
			wack_d_ff <= direct_path_confirm_i;
			word_d_ff <= word;
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
		begin
			nv_wr_o <= 1'b0;
			nv_pos_o <= POS_REST;
			pos_bin_o <= POS_REST;
			pos_onehot_o <= 8'h01;
			pos_changed_o <= 1'b0;
			pending_o <= 1'b0;
			pending_pos_o <= POS_REST;
		end
		else
		begin
			nv_wr_o <= apply;
			nv_pos_o <= nxt_pos;
			pos_bin_o <= nxt_pos;
			pos_onehot_o <= 8'h01 << nxt_pos;
			pos_changed_o <= apply && (nxt_pos != pos_ff);
			pending_o <= (nxt_state != PSS_IDLE);
			pending_pos_o <= nxt_pre;
		end
	end

	pss_alarm u_step_alarm
	(
		.core_clk_i(core_clk_i),
		.srst_i(srst_i),
		.tick_i(tick),
		.trig_i(trig_step),
		.alarm_o(alarm_o.step_alarm)
	);

	pss_alarm u_range_alarm
	(
		.core_clk_i(core_clk_i),
		.srst_i(srst_i),
		.tick_i(tick),
		.trig_i(trig_range),
		.alarm_o(alarm_o.range_alarm)
	);

	pss_alarm u_word_alarm
	(
		.core_clk_i(core_clk_i),
		.srst_i(srst_i),
		.tick_i(tick),
		.trig_i(trig_word),
		.alarm_o(alarm_o.word_alarm)
	);

	pss_alarm u_pwr_alarm
	(
		.core_clk_i(core_clk_i),
		.srst_i(srst_i),
		.tick_i(tick),
		.trig_i(trig_pwr),
		.alarm_o(alarm_o.powerup_position_alarm)
	);
endmodule

// >>> tb/pss_top_properties.sv
`timescale 1ns/1ns
module pss_top_properties
	import pss_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic srst_i,
	input wire pss_cfg_t cfg_i,
	input wire logic step_up_i,
	input wire logic step_confirm_i,
	input wire logic direct_word_bit0_i,
	input wire logic direct_word_bit1_i,
	input wire logic direct_word_bit2_i,
	input wire logic powerup_i,
	input wire logic [2:0] nv_pos_i,
	input wire logic nv_wr_o,
	input wire logic [2:0] nv_pos_o,
	input wire logic [2:0] pos_bin_o,
	input wire logic [7:0] pos_onehot_o,
	input wire logic pos_changed_o,
	input wire logic pending_o,
	input wire logic [2:0] pending_pos_o,
	input wire pss_alarm_t alarm_o
);
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (srst_i);
	logic [2:0] word;
	logic [2:0] wrap_pos;
	logic [2:0] pu_src;
	logic pu_bad;
	logic rise;
	logic step_prev_ff;
	logic step_path_ff;
	assign word = {direct_word_bit2_i, direct_word_bit1_i, direct_word_bit0_i};
	assign rise = step_up_i && !step_prev_ff && !powerup_i;
	assign wrap_pos = (pos_bin_o >= cfg_i.upper_pos) ? POS_FIRST :
		pos_bin_o + 3'h1;
	assign pu_src = (cfg_i.pwr_mode == PSS_SYNC) ? word : nv_pos_i;
	assign pu_bad = (pu_src == POS_REST) || (pu_src > cfg_i.upper_pos);
	// remembers that the pending sequence was opened by the step input
	always_ff @(posedge core_clk_i)
	begin
		step_prev_ff <= srst_i ? 1'b0 : step_up_i;
		if (srst_i)
			step_path_ff <= 1'b0;
		else if (!pending_o)
			step_path_ff <= rise;
	end
	onehot_binary_a: assert property (pos_onehot_o == 8'h01 << pos_bin_o)
		else $error("onehot and binary position disagree");
	nv_mirror_a: assert property (nv_wr_o |-> nv_pos_o == pos_bin_o)
		else $error("stored position differs from applied");
	change_event_a: assert property (pos_changed_o |->
		pos_bin_o != $past(pos_bin_o))
		else $error("change event without new position");
	step_wrap_a: assert property (!pending_o && rise |=> pending_o &&
		pending_pos_o == $past(wrap_pos))
		else $error("step pre-selection wrong");
	word_lock_a: assert property (pending_o && step_path_ff && !rise &&
		!powerup_i |=> !pending_o || $stable(pending_pos_o))
		else $error("pre-selection moved during step sequence");
	step_ack_a: assert property (pending_o && step_path_ff && !rise &&
		cfg_i.step_mode == PSS_ACK && $rose(step_confirm_i) && !powerup_i
		|=> !pending_o && pos_bin_o == $past(pending_pos_o))
		else $error("step confirm did not apply");
	range_refuse_a: assert property (!pending_o && !rise && !powerup_i &&
		word > cfg_i.upper_pos && word != $past(word)
		|=> alarm_o.range_alarm && !pending_o)
		else $error("out of range word not refused");
	rest_word_a: assert property (!pending_o && !rise && !powerup_i &&
		word == 3'h0 |=> !pending_o && !pos_changed_o)
		else $error("rest word caused action");
	powerup_load_a: assert property (powerup_i |=> pos_bin_o ==
		($past(pu_bad) ? POS_REST : $past(pu_src)) &&
		(!$past(pu_bad) || alarm_o.powerup_position_alarm))
		else $error("power-up position wrong");
	alarm_hold_a: assert property ($rose(alarm_o.range_alarm) |->
		alarm_o.range_alarm [*8])
		else $error("range alarm dropped early");
	cover property (!pending_o && rise);
	cover property (pos_changed_o);
	cover property ($rose(alarm_o.word_alarm));
endmodule
bind pss_top pss_top_properties i_pss_top_properties (.*);

// >>> tb/pss_operator.sv
`timescale 1ns/1ns
module pss_operator
	import pss_pkg::*;
(
	input wire logic core_clk_i,
	output logic step_up_o,
	output logic step_ack_o,
	output logic [2:0] word_o,
	output logic word_ack_o
);
	localparam int GAP = CLK_HZ / 1000 * STEP_SPACING_MS;
	int since = GAP;
	initial
	begin
		step_up_o = 1'b0;
		step_ack_o = 1'b0;
		word_o = 3'h0;
		word_ack_o = 1'b0;
	end
	always @(posedge core_clk_i)
		since <= since + 1;
	// one-cycle press: 0 step, 1 step confirm, 2 word confirm
	task automatic press(input int sel);
		while (sel == 0 && since < GAP)
			@(negedge core_clk_i);
		@(negedge core_clk_i);
		step_up_o = (sel == 0);
		step_ack_o = (sel == 1);
		word_ack_o = (sel == 2);
		if (sel == 0)
			since = 0;
		@(negedge core_clk_i);
		step_up_o = 1'b0;
		step_ack_o = 1'b0;
		word_ack_o = 1'b0;
	endtask
	task automatic set_word(input logic [2:0] w);
		@(negedge core_clk_i);
		word_o = w;
	endtask
endmodule

// >>> tb/tb_top.sv
`timescale 1ns/1ns
module tb_top
	import pss_pkg::*;
;
	logic core_clk_i = 1'b0;
	logic srst_i = 1'b1;
	pss_cfg_t cfg;
	logic su, sa, wa, pu, nvw, chg, pend;
	logic [2:0] wd, nvp, nvo, pbin, ppos, w;
	logic [7:0] oh;
	pss_alarm_t al;
	logic [2:0] expq[$];
	logic [2:0] exp_pos;
	logic pu_win = 1'b0;
	int n_errors = 0;
	int num_checks = 0;
	always #25 core_clk_i = ~core_clk_i;
	pss_operator i_pss_operator (.core_clk_i(core_clk_i), .step_up_o(su),
		.step_ack_o(sa), .word_o(wd), .word_ack_o(wa));
	pss_top i_pss_top (.core_clk_i(core_clk_i), .srst_i(srst_i),
		.cfg_i(cfg), .step_up_i(su), .step_confirm_i(sa),
		.direct_word_bit0_i(wd[0]), .direct_word_bit1_i(wd[1]),
		.direct_word_bit2_i(wd[2]), .direct_path_confirm_i(wa),
		.powerup_i(pu), .nv_pos_i(nvp), .nv_wr_o(nvw), .nv_pos_o(nvo),
		.pos_bin_o(pbin), .pos_onehot_o(oh), .pos_changed_o(chg),
		.pending_o(pend), .pending_pos_o(ppos), .alarm_o(al));
	task automatic check(input logic [11:0] got, input logic [11:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic conclude();
		$display("checks=%0d errors=%0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic idle_wait(input int n);
		int i;
		for (i = 0; i < n && pend !== 1'b0; i++)
			@(negedge core_clk_i);
		if (pend !== 1'b0)
		begin
			n_errors++;
			conclude();
		end
	endtask
	task automatic power_up(input logic [2:0] nv, input pss_pwr_t m,
		input logic [2:0] e, input logic a);
		cfg.pwr_mode = m;
		nvp = nv;
		pu_win = 1'b1;
		pu = 1'b1;
		@(negedge core_clk_i);
		pu = 1'b0;
		@(negedge core_clk_i);
		check({3'h0, al.powerup_position_alarm, oh}, {3'h0, a, 8'h01 << e});
		pu_win = 1'b0;
	endtask
	// applied positions are compared in order of arrival
	always @(negedge core_clk_i)
		if (chg === 1'b1 && !pu_win)
		begin
			if (expq.size() == 0)
				check(12'hfff, {9'h000, pbin});
			else
			begin
				exp_pos = expq.pop_front();
				check({5'h00, nvw, nvo, pbin},
					{6'h01, exp_pos, exp_pos});
			end
		end
	task automatic settle();
		repeat (2) @(negedge core_clk_i);
	endtask
	initial
	begin
		cfg = '{3'h3, 12'h002, PSS_ACK, PSS_ACK, PSS_RESTORE};
		pu = 1'b0;
		nvp = 3'h0;
		w = 3'($urandom(32196));
		repeat (5) @(negedge core_clk_i);
		srst_i = 1'b0;
		check({pend, al, oh[6:0]}, 12'h001);
		power_up(3'h3, PSS_RESTORE, 3'h3, 1'b0);
		power_up(3'h3, PSS_SYNC, 3'h0, 1'b1);
		power_up(3'h2, PSS_RESTORE, 3'h2, 1'b1);
		power_up(3'h5, PSS_RESTORE, 3'h0, 1'b1);
		power_up(3'h3, PSS_RESTORE, 3'h3, 1'b1);
		i_pss_operator.set_word(3'h7);
		settle();
		check(12'({pend, al.range_alarm}), 12'h001);
		i_pss_operator.set_word(3'h0);
		settle();
		check(12'({pend, pbin}), 12'h003);
		i_pss_operator.press(0);
		settle();
		check(12'({pend, ppos}), 12'h009);
		i_pss_operator.set_word(3'h2);
		i_pss_operator.press(2);
		settle();
		check(12'({pend, ppos, pbin}), 12'h04b);
		expq.push_back(3'h1);
		i_pss_operator.press(1);
		idle_wait(10);
		i_pss_operator.set_word(3'h0);
		w = 3'h2 + 3'($urandom % 2);
		i_pss_operator.set_word(w);
		settle();
		check(12'({pend, ppos}), {8'h00, 1'b1, w});
		expq.push_back(w);
		i_pss_operator.press(2);
		idle_wait(10);
		cfg.timeout_ticks = 12'h001;
		i_pss_operator.set_word(3'h1);
		settle();
		idle_wait(30000);
		settle();
		check(12'({al.word_alarm, pbin}), {8'h00, 1'b1, w});
		cfg.direct_path_apply_mode = PSS_TIMEOUT;
		expq.push_back(3'h5 - w);
		i_pss_operator.set_word(3'h5 - w);
		settle();
		idle_wait(30000);
		w = 3'h4 + 3'($urandom % 4);
		cfg.upper_pos = w;
		expq.push_back(w);
		i_pss_operator.set_word(w);
		settle();
		idle_wait(30000);
		settle();
		check(12'(expq.size()), 12'h000);
		conclude();
	end
endmodule
